// [pmt_table_read.sv]
/*
  program store with table read, serial programming and debug port.
  assumes the core pulses tab_start_in once per table instruction and that the
  programmer is the only driver of the serial pins while it programs.
*/
// Notes on behaviour
// - store holds 16-bit words, 2K or 4K deep
// - after reset fetch starts at word zero
// - table address from high and low pointers
// - low byte goes to chosen data register
// - high byte goes into table high latch
// - unsupplied high byte bits read as zero
// - table high latch is read-only to software
// - table instructions take two instruction cycles
// - general table read uses both pointers
// - serial data both ways, programmer drives clock
// - programming port writes program store and eeprom
// - debug data bidirectional, debug clock input only
// - emulation variant disables shared pin functions
// - debug pins still serve serial programming
module pmt_table_read
  import pmt_pkg::*;
#(
  parameter int DEPTH = PMT_DEPTH_SMALL,
  parameter int HIGH_BITS = 8,
  parameter bit EMULATION = 1'b0
)(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // fetch
  input wire logic [11:0] pc_in,
  output logic [15:0] fetch_word_out,
  output logic [11:0] fetch_addr_out,
  // table read
  input wire logic tab_start_in,
  input wire logic tab_last_page_in,
  input wire logic [7:0] tbl_ptr_low_in,
  input wire logic [7:0] tbl_ptr_high_in,
  input wire logic [7:0] tab_dest_in,
  input wire logic latch_wr_in,
  input wire logic [7:0] latch_wdata_in,
  output logic tab_busy_out,
  output logic tab_done_out,
  output logic [7:0] tab_dest_out,
  output logic [7:0] tab_low_out,
  output logic [7:0] table_high_latch_out,
  // serial programming / debug pins
  input wire logic prog_mode_in,
  input wire logic prog_serial_clock_in,
  input wire logic prog_serial_data_in,
  output logic prog_serial_data_out,
  output logic prog_serial_data_oe_out,
  // eeprom write request
  output logic ee_wr_out,
  output logic [11:0] ee_addr_out,
  output logic [7:0] ee_data_out,
  // shared pin function gate
  output logic shared_pin_en_out
);
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH != PMT_DEPTH_SMALL && DEPTH != PMT_DEPTH_LARGE)
      $error("DEPTH must be 2048 or 4096");
    if (HIGH_BITS < 1 || HIGH_BITS > 8)
      $error("HIGH_BITS must be 1..8");
  end

  function automatic logic [AW-1:0] tab_addr(input logic last, input logic [7:0] hi,
                                             input logic [7:0] lo);
    logic [11:0] full;
    full = last ? {4'hf, lo} : {hi[3:0], lo};
    tab_addr = full[AW-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // program store
  logic [PMT_WORD_W-1:0] mem [DEPTH];
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [15:0] mem_wdata;

  always_ff @(posedge sys_clk_in)
  begin
    if (mem_we)
      mem[mem_waddr] <= mem_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // fetch path
  logic [15:0] fetch_word, next_fetch_word;
  logic [11:0] fetch_addr, next_fetch_addr;

  always_comb
  begin
    next_fetch_addr = srst_in ? PMT_RESET_VECTOR : pc_in;
    next_fetch_word = srst_in ? 16'h0000 : mem[next_fetch_addr[AW-1:0]];
  end

  always_ff @(posedge sys_clk_in)
  begin
    fetch_addr <= next_fetch_addr;
    fetch_word <= next_fetch_word;
  end
  assign fetch_addr_out = fetch_addr;
  assign fetch_word_out = fetch_word;

  ////////////////////////////////////////////////////////////////////////////
  // table read, two cycles
  typedef enum logic [1:0] {PMT_IDLE, PMT_FETCH, PMT_COMMIT} pmt_tab_e;
  pmt_tab_e tstate, next_tstate;
  logic [AW-1:0] taddr, next_taddr;
  logic [7:0] tdest, next_tdest;
  logic [15:0] tword, next_tword;
  logic [7:0] latch, next_latch;
  logic [7:0] low, next_low;
  logic done, next_done;
  logic [7:0] hi_mask;

  always_comb
  begin
    hi_mask = 8'((9'h001 << HIGH_BITS) - 9'h001);
    next_tstate = tstate;
    next_taddr = taddr;
    next_tdest = tdest;
    next_tword = tword;
    next_latch = latch;
    next_low = low;
    next_done = 1'b0;
    unique case (tstate)
      PMT_IDLE:
      begin
        if (tab_start_in)
        begin
          next_taddr = tab_addr(tab_last_page_in, tbl_ptr_high_in, tbl_ptr_low_in);
          next_tdest = tab_dest_in;
          next_tstate = PMT_FETCH;
        end
      end
      PMT_FETCH:
      begin
        next_tword = mem[taddr];
        next_tstate = PMT_COMMIT;
      end
      PMT_COMMIT:
      begin
        next_low = tword[7:0];
        next_latch = tword[15:8] & hi_mask;
        next_done = 1'b1;
        next_tstate = PMT_IDLE;
      end
    endcase
    if (latch_wr_in)
      next_latch = next_latch;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      tstate <= PMT_IDLE;
      taddr <= '0;
      tdest <= 8'h00;
      tword <= 16'h0000;
      latch <= PMT_LATCH_RESET;
      low <= 8'h00;
      done <= 1'b0;
    end
    else
    begin
      tstate <= next_tstate;
      taddr <= next_taddr;
      tdest <= next_tdest;
      tword <= next_tword;
      latch <= next_latch;
      low <= next_low;
      done <= next_done;
    end
  end

  logic busy_q;
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      busy_q <= 1'b0;
    else
      busy_q <= (next_tstate != PMT_IDLE);
  end
  assign tab_busy_out = busy_q;
  assign tab_done_out = done;
  assign tab_dest_out = tdest;
  assign tab_low_out = low;
  assign table_high_latch_out = latch;

  ////////////////////////////////////////////////////////////////////////////
  // serial link: pins sampled through three flops
  logic [2:0] ck_sync, dt_sync, md_sync;
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      ck_sync <= 3'h0;
      dt_sync <= 3'h0;
      md_sync <= 3'h0;
    end
    else
    begin
      ck_sync <= {ck_sync[1:0], prog_serial_clock_in};
      dt_sync <= {dt_sync[1:0], prog_serial_data_in};
      md_sync <= {md_sync[1:0], prog_mode_in};
    end
  end

  logic ck_q, next_ck_q;
  logic ck_rise, ck_fall, mode_on;
  logic [PMT_SHIFT_W-1:0] shreg, next_shreg;
  logic [4:0] bitcnt, next_bitcnt;
  logic sd_out, next_sd_out, sd_oe, next_sd_oe;
  logic ee_wr, next_ee_wr;
  logic [11:0] ee_addr, next_ee_addr;
  logic [7:0] ee_data, next_ee_data;
  logic [15:0] rd_word;

  always_comb
  begin
    // a level counts once stages two and three agree
    next_ck_q = (ck_sync[2] == ck_sync[1]) ? ck_sync[2] : ck_q;
    ck_rise = (next_ck_q && !ck_q);
    ck_fall = (!next_ck_q && ck_q);
    mode_on = md_sync[2] & md_sync[1];
    // read address: AW-1 bits already shifted plus the bit arriving now
    rd_word = mem[{shreg[AW-2:0], dt_sync[2]}];
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_sd_out = sd_out;
    next_sd_oe = sd_oe;
    next_ee_wr = 1'b0;
    next_ee_addr = ee_addr;
    next_ee_data = ee_data;
    mem_we = 1'b0;
    mem_waddr = '0;
    mem_wdata = 16'h0000;
    if (!mode_on)
    begin
      next_bitcnt = 5'd0;
      next_sd_oe = 1'b0;
    end
    else if (ck_rise && !sd_oe)
    begin
      next_shreg = {shreg[PMT_SHIFT_W-2:0], dt_sync[2]};
      next_bitcnt = bitcnt + 5'd1;
      if (32'(bitcnt) + 1 == PMT_READ_BITS && shreg[12:11] == PMT_OP_READ)
      begin
        next_shreg = {rd_word, 16'h0000};
        next_sd_oe = 1'b1;
        next_bitcnt = 5'd0;
      end
      else if (32'(bitcnt) + 1 == PMT_FRAME_BITS)
      begin
        next_bitcnt = 5'd0;
        if (shreg[28:27] == PMT_OP_WR_PROG)
        begin
          mem_we = 1'b1;
          mem_waddr = shreg[15 +: AW];
          mem_wdata = {shreg[14:0], dt_sync[2]};
        end
        else if (shreg[28:27] == PMT_OP_WR_EE)
        begin
          next_ee_wr = 1'b1;
          next_ee_addr = shreg[26:15];
          next_ee_data = {shreg[6:0], dt_sync[2]};
        end
      end
    end
    else if (ck_fall && sd_oe)
    begin
      next_sd_out = shreg[PMT_SHIFT_W-1];
      next_shreg = {shreg[PMT_SHIFT_W-2:0], 1'b0};
      next_bitcnt = bitcnt + 5'd1;
      if (bitcnt == 5'd16)
      begin
        next_sd_oe = 1'b0;
        next_bitcnt = 5'd0;
      end
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      ck_q <= 1'b0;
      shreg <= '0;
      bitcnt <= 5'd0;
      sd_out <= 1'b0;
      sd_oe <= 1'b0;
      ee_wr <= 1'b0;
      ee_addr <= 12'h000;
      ee_data <= 8'h00;
    end
    else
    begin
      ck_q <= next_ck_q;
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      sd_out <= next_sd_out;
      sd_oe <= next_sd_oe;
      ee_wr <= next_ee_wr;
      ee_addr <= next_ee_addr;
      ee_data <= next_ee_data;
    end
  end
  assign prog_serial_data_out = sd_out;
  assign prog_serial_data_oe_out = sd_oe;
  assign ee_wr_out = ee_wr;
  assign ee_addr_out = ee_addr;
  assign ee_data_out = ee_data;

  logic shared_en;
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
      shared_en <= 1'b0;
    else
      shared_en <= !EMULATION && !mode_on;
  end
  assign shared_pin_en_out = shared_en;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_two_cycle;
    @(posedge sys_clk_in) disable iff (srst_in)
      (tstate == PMT_IDLE && tab_start_in) |-> ##2 !done ##1 done;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("table read not two cycles");

  property p_latch_hold;
    @(posedge sys_clk_in) disable iff (srst_in)
      !done |-> $stable(latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed without read");

  property p_hi_zero;
    @(posedge sys_clk_in) disable iff (srst_in)
      (latch & ~hi_mask) == 8'h00;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("unused high bits set");

  property p_together;
    @(posedge sys_clk_in) disable iff (srst_in)
      $changed(low) |-> done;
  endproperty
  a_together: assert property (p_together) else $error("low byte moved alone");

  property p_reset_vec;
    @(posedge sys_clk_in) srst_in |=> fetch_addr == PMT_RESET_VECTOR;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset fetch not at zero");

  property p_last_page;
    @(posedge sys_clk_in) disable iff (srst_in)
      (tstate == PMT_IDLE && tab_start_in && tab_last_page_in)
        |=> taddr == AW'({4'hf, $past(tbl_ptr_low_in)});
  endproperty
  a_last_page: assert property (p_last_page) else $error("last page address wrong");

  property p_drive_mode;
    @(posedge sys_clk_in) disable iff (srst_in)
      !mode_on |=> !sd_oe;
  endproperty
  a_drive_mode: assert property (p_drive_mode) else $error("data driven outside mode");

  property p_emul;
    @(posedge sys_clk_in) disable iff (srst_in)
      (EMULATION || mode_on) |=> !shared_en;
  endproperty
  a_emul: assert property (p_emul) else $error("shared pins live on emulation");
endmodule // pmt_table_read

// [pmt_pkg.sv]
/*
  shared constants for the program memory table-read block.
  assumes a core that issues one table request per two-cycle table instruction.
*/
package pmt_pkg;
  localparam int PMT_WORD_W = 16;
  localparam int PMT_DEPTH_SMALL = 2048;
  localparam int PMT_DEPTH_LARGE = 4096;
  localparam logic [11:0] PMT_RESET_VECTOR = 12'h000;
  localparam logic [7:0] PMT_LATCH_RESET = 8'h00;
  localparam int PMT_PAGE_WORDS = 256;
  localparam int PMT_TABLE_CYCLES = 2;
  localparam int PMT_SYNC_STAGES = 3;
  // 20 MHz clock, link clock period 400 ns gives 8 cycles per link bit
  localparam int PMT_CLK_NS = 50;
  localparam int PMT_LINK_NS = 400;
  localparam int PMT_LINK_CYCLES = PMT_LINK_NS / PMT_CLK_NS;
  localparam int PMT_SHIFT_W = 32;
  // serial frame: 2 op bits, 12 address bits, 16 data bits
  localparam logic [1:0] PMT_OP_READ = 2'h0;
  localparam logic [1:0] PMT_OP_WR_PROG = 2'h1;
  localparam logic [1:0] PMT_OP_WR_EE = 2'h2;
  localparam int PMT_FRAME_BITS = 30;
  localparam int PMT_READ_BITS = 14;
endpackage

// [pmt_prog_model.sv]
/*
  serial programmer model for the shared data line and link clock.
  assumes the device samples both pins with its own, faster clock.
*/
module pmt_prog_model (
  // device side of the shared data line
  input wire logic dev_data_in,
  input wire logic dev_oe_in,
  // programmer pins
  output logic ser_clk_out,
  output logic ser_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv_en;
  logic drv_val;
  logic last_val;
  initial
  begin
    ser_clk_out = 1'b0;
    drv_en = 1'b0;
    drv_val = 1'b0;
    last_val = 1'b0;
  end
  // released line shows the inverse of the last driven level
  always_comb ser_data_out = dev_oe_in ? dev_data_in : (drv_en ? drv_val : ~last_val);
  always @(negedge dev_oe_in) last_val = dev_data_in;
  ////////////////////////////////////////////////////////////////////////////////
  // top n bits, msb first; clock idles low between frames
  task automatic send_bits(input logic [29:0] bits, input int n);
    for (int i = 29; i >= 30 - n; i--)
    begin
      drv_en = 1'b1;
      drv_val = bits[i];
      #200 ser_clk_out = 1'b1;
      #200 ser_clk_out = 1'b0;
    end
    last_val = drv_val;
    drv_en = 1'b0;
  endtask
  // device changes data on falling edges, so sample inside the high phase
  task automatic read_bits(output logic [15:0] w, output logic oe_ok);
    oe_ok = 1'b1;
    for (int i = 15; i >= 0; i--)
    begin
      #200 ser_clk_out = 1'b1;
      #100 w[i] = ser_data_out;
      oe_ok = oe_ok & dev_oe_in;
      #100 ser_clk_out = 1'b0;
    end
  endtask
endmodule // pmt_prog_model

// [test_pmt_table_read.sv]
/*
  self-checking bench for the table-read block.
  assumes pmt_table_read and pmt_prog_model are compiled beforehand.
*/
module test_pmt_table_read;
  timeunit 1ns;
  timeprecision 1ns;
  import pmt_pkg::*;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [11:0] pc_in = 12'h555;
  logic tab_start_in = 1'b0;
  logic tab_last_page_in = 1'b0;
  logic [7:0] tbl_ptr_low_in = 8'h00;
  logic [7:0] tbl_ptr_high_in = 8'h00;
  logic [7:0] tab_dest_in = 8'h00;
  logic latch_wr_in = 1'b0;
  logic [7:0] latch_wdata_in = 8'h00;
  logic prog_mode_in = 1'b0;
  logic prog_serial_clock_in;
  logic prog_serial_data_in;
  logic [15:0] fetch_word_out;
  logic [11:0] fetch_addr_out;
  logic tab_busy_out;
  logic tab_done_out;
  logic [7:0] tab_dest_out;
  logic [7:0] tab_low_out;
  logic [7:0] table_high_latch_out;
  logic prog_serial_data_out;
  logic prog_serial_data_oe_out;
  logic ee_wr_out;
  logic [11:0] ee_addr_out;
  logic [7:0] ee_data_out;
  logic shared_pin_en_out;
  logic [11:0] ee_addr;
  logic [7:0] ee_data;
  logic [15:0] rd_word;
  logic rd_oe;
  int ee_cnt = 0;
  int cycles = 0;
  int failures = 0;
  int num_checks = 0;
  pmt_table_read #(.HIGH_BITS(6)) pmt_table_read_i (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .pc_in(pc_in),
    .fetch_word_out(fetch_word_out),
    .fetch_addr_out(fetch_addr_out),
    .tab_start_in(tab_start_in),
    .tab_last_page_in(tab_last_page_in),
    .tbl_ptr_low_in(tbl_ptr_low_in),
    .tbl_ptr_high_in(tbl_ptr_high_in),
    .tab_dest_in(tab_dest_in),
    .latch_wr_in(latch_wr_in),
    .latch_wdata_in(latch_wdata_in),
    .tab_busy_out(tab_busy_out),
    .tab_done_out(tab_done_out),
    .tab_dest_out(tab_dest_out),
    .tab_low_out(tab_low_out),
    .table_high_latch_out(table_high_latch_out),
    .prog_mode_in(prog_mode_in),
    .prog_serial_clock_in(prog_serial_clock_in),
    .prog_serial_data_in(prog_serial_data_in),
    .prog_serial_data_out(prog_serial_data_out),
    .prog_serial_data_oe_out(prog_serial_data_oe_out),
    .ee_wr_out(ee_wr_out),
    .ee_addr_out(ee_addr_out),
    .ee_data_out(ee_data_out),
    .shared_pin_en_out(shared_pin_en_out)
  );
  pmt_prog_model pmt_prog_model_i (
    .dev_data_in(prog_serial_data_out),
    .dev_oe_in(prog_serial_data_oe_out),
    .ser_clk_out(prog_serial_clock_in),
    .ser_data_out(prog_serial_data_in)
  );
  initial
  begin
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in)
  begin
    if (ee_wr_out === 1'b1)
    begin
      ee_cnt++;
      ee_addr = ee_addr_out;
      ee_data = ee_data_out;
    end
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_prog;
    prog_mode_in = 1'b1;
    step(4);
    check(shared_pin_en_out, 1'b0);
    pmt_prog_model_i.send_bits({PMT_OP_WR_PROG, 12'h123, 16'hc5a3}, 30);
    pmt_prog_model_i.send_bits({PMT_OP_WR_PROG, 12'h706, 16'hff1a}, 30);
    pmt_prog_model_i.send_bits({PMT_OP_WR_EE, 12'h045, 16'h0077}, 30);
    step(8);
    check(16'(ee_cnt), 16'h0001);
    check(ee_addr, 12'h045);
    check(ee_data, 8'h77);
    pmt_prog_model_i.send_bits({PMT_OP_READ, 12'h706, 16'h0000}, 14);
    pmt_prog_model_i.read_bits(rd_word, rd_oe);
    check(rd_word, 16'hff1a);
    check(rd_oe, 1'b1);
    step(8);
    check(prog_serial_data_oe_out, 1'b0);
    prog_mode_in = 1'b0;
    step(4);
    check(shared_pin_en_out, 1'b1);
  endtask
  task automatic t_fetch;
    pc_in = 12'h123;
    step(2);
    check(fetch_addr_out, 12'h123);
    check(fetch_word_out, 16'hc5a3);
  endtask
  task automatic t_tab(input logic last, input logic [7:0] lo, input logic [7:0] hi,
                       input logic [7:0] dest, input logic [7:0] exp_lo,
                       input logic [7:0] exp_hi);
    tab_start_in = 1'b1;
    tab_last_page_in = last;
    tbl_ptr_low_in = lo;
    tbl_ptr_high_in = hi;
    tab_dest_in = dest;
    step(1);
    check(tab_busy_out, 1'b1);
    tbl_ptr_low_in = ~lo;
    tab_dest_in = ~dest;
    step(1);
    tab_start_in = 1'b0;
    check(tab_done_out, 1'b0);
    check(tab_busy_out, 1'b1);
    step(1);
    check(tab_done_out, 1'b1);
    check(tab_busy_out, 1'b0);
    check(tab_low_out, exp_lo);
    check(table_high_latch_out, exp_hi);
    check(tab_dest_out, dest);
    step(1);
    check(tab_done_out, 1'b0);
  endtask
  task automatic t_latch;
    latch_wr_in = 1'b1;
    latch_wdata_in = 8'h3c;
    step(1);
    latch_wr_in = 1'b0;
    step(2);
    check(table_high_latch_out, 8'h3f);
  endtask
  initial
  begin
    step(6);
    check(fetch_addr_out, 12'h000);
    check(table_high_latch_out, PMT_LATCH_RESET);
    srst_in = 1'b0;
    pc_in = 12'h000;
    step(2);
    check(fetch_addr_out, 12'h000);
    t_prog();
    t_fetch();
    t_tab(1'b0, 8'h23, 8'hf1, 8'h5a, 8'ha3, 8'h05);
    t_tab(1'b1, 8'h06, 8'h00, 8'ha5, 8'h1a, 8'h3f);
    t_latch();
    results();
  end
endmodule // test_pmt_table_read
